// File: rtl/pin_mux_pkg.sv
// Shared constants and carrier types for the quad UART pin function mux
`default_nettype none

package pin_mux_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_GPIO = 16;
  localparam int NUM_UART = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_GPIO_MODE = 8'h00;   // 2 bits per pin
  localparam logic [7:0] OFS_GPIO_OUT = 8'h04;    // Output levels
  localparam logic [7:0] OFS_GPIO_IN = 8'h08;     // Synced pin levels
  localparam logic [7:0] OFS_EVENT = 8'h0c;       // Sticky events, W1C
  localparam logic [7:0] OFS_TX_SYNC = 8'h10;     // transmit_sync_control
  localparam logic [7:0] OFS_TIMER_HIGH = 8'h14;  // timer_high_control
  localparam logic [7:0] OFS_CLK_SRC = 8'h18;     // clock_source_select
  localparam logic [7:0] OFS_FLOW_STAT = 8'h1c;   // CTS and RX levels
  localparam logic [7:0] OFS_LINE_CTRL0 = 8'h20;  // line_control, ch n at +4n
  localparam logic [7:0] LINE_CTRL_STRIDE = 8'h04;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int OVR_BIT = 7;          // Override enable in control regs
  localparam int CLK_SRC_DIV_BIT = 0;  // 1 selects fractional divider
  localparam int LINE_CTRL_RTS_BIT = 7; // 1 asserts request (pin low)
  localparam int FLOW_RX_POS = 4;      // RX levels above CTS levels

  // Pins that can be taken over by the reference clock or timer
  localparam logic [15:0] REFCLK_PINS = 16'h0111;
  localparam logic [15:0] TIMER_PINS = 16'h0022;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [31:0] RST_GPIO_MODE = 32'h0000_0000;
  localparam logic [15:0] RST_GPIO_OUT = 16'h0000;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [23:0] RST_PIN_SYNC = 24'hff_0000; // rx,cts idle high
  localparam logic [31:0] RST_RD_DATA = 32'h0000_0000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0]
  {
    MODE_INPUT = 2'h0,
    MODE_PUSH_PULL = 2'h1,
    MODE_OPEN_DRAIN = 2'h2,
    MODE_EVENT = 2'h3
  } gpio_mode_t;

  // One register bus request
  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  // Drive of all general-purpose pins
  typedef struct packed
  {
    logic [NUM_GPIO-1:0] level;
    logic [NUM_GPIO-1:0] enable;
  } gpio_drive_t;

endpackage

`default_nettype wire

// File: rtl/quad_uart_pin_function_mux.sv
// Pin function mux for four UART channels and sixteen general pins
//
// Our own choices: the address-and-strobe port and the address map.
`default_nettype none

// Contract
// - Each pin: input, push-pull, open-drain, event
// - Event-mode pin activity raises an event
// - Sync control bit 7 drives reference clock
// - Timer high bit 7 drives timer output
// - Line control bit sets request-to-send level
// - Clock source bit 7 puts clock on RTS
// - Clear-to-send input sampled as flow status
// - Each channel owns its RX and TX
// - Interrupt output low while event pending
// - Reset holds all pins quiet and safe
module quad_uart_pin_function_mux
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register bus
  input wire pin_mux_pkg::bus_req_t bus_req,
  output logic [31:0] rd_data,
  // Internal sources that may be routed to pins
  input wire logic ref_clock_level,
  input wire logic timer_level,
  input wire logic uart_sys_clk_level,
  input wire logic frac_div_level,
  input wire logic [3:0] uart_txd,
  // General-purpose pins
  input wire logic [15:0] gpio_in_pin,
  output pin_mux_pkg::gpio_drive_t gpio_drive,
  // UART pins
  output logic [3:0] tx_pin,
  input wire logic [3:0] rx_pin,
  output logic [3:0] rts_n_pin,
  input wire logic [3:0] cts_n_pin,
  // Toward the UART cores and host
  output logic [3:0] uart_rxd,
  output logic [3:0] cts_active,
  output logic irq_n
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0] gpio_mode_reg;    // Per-pin function
  logic [15:0] gpio_out_reg;     // Software output levels
  logic [15:0] event_reg;        // Sticky pin events
  logic [7:0] tx_sync_reg;       // transmit_sync_control
  logic [7:0] timer_high_reg;    // timer_high_control
  logic [7:0] clk_src_reg;       // clock_source_select
  logic [7:0] line_ctrl_reg [4]; // line_control per channel
  logic [23:0] pin_sync;         // {rx, cts_n, gpio} after two flops
  logic [15:0] gpio_sync;        // Synced general pins
  logic [3:0] cts_n_sync;        // Synced clear-to-send
  logic [3:0] rx_sync;           // Synced receive data
  logic [15:0] gpio_prev_reg;    // For edge detection
  logic [15:0] event_set;        // New events this cycle
  logic [15:0] event_clr;        // Software clear this cycle
  pin_mux_pkg::gpio_drive_t drive_next;
  logic [3:0] rts_next;
  logic [31:0] rd_data_next;

  // ************************************************************
  // Functions
  // ************************************************************
  // Function of one pin from the mode word
  function automatic pin_mux_pkg::gpio_mode_t mode_of(
    input logic [31:0] modes, input int pin);
    mode_of = pin_mux_pkg::gpio_mode_t'(modes[2*pin +: 2]);
  endfunction

  // Byte offset of a channel's line control register
  function automatic logic [7:0] line_ofs(input int ch);
    line_ofs = pin_mux_pkg::OFS_LINE_CTRL0
      + 8'(ch * pin_mux_pkg::LINE_CTRL_STRIDE);
  endfunction

  // ************************************************************
  // Pin input synchronisers
  // ************************************************************
  sync_bits
  #(
    .WIDTH(24),
    .RESET_VALUE(pin_mux_pkg::RST_PIN_SYNC)
  )
  u_pin_sync
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({rx_pin, cts_n_pin, gpio_in_pin}),
    .sync_out(pin_sync)
  );

  assign gpio_sync = pin_sync[15:0];
  assign cts_n_sync = pin_sync[19:16];
  assign rx_sync = pin_sync[23:20];

  // ************************************************************
  // Control registers
  // ************************************************************
  // Software writes; reset leaves every pin an input, no override
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      gpio_mode_reg <= pin_mux_pkg::RST_GPIO_MODE;
      gpio_out_reg <= pin_mux_pkg::RST_GPIO_OUT;
      tx_sync_reg <= pin_mux_pkg::RST_CTRL;
      timer_high_reg <= pin_mux_pkg::RST_CTRL;
      clk_src_reg <= pin_mux_pkg::RST_CTRL;
      for (int c = 0; c < pin_mux_pkg::NUM_UART; c++)
      begin
        line_ctrl_reg[c] <= pin_mux_pkg::RST_CTRL;
      end
    end
    else if (bus_req.wr)
    begin
      // Address decode
      if (bus_req.addr == pin_mux_pkg::OFS_GPIO_MODE)
      begin
        gpio_mode_reg <= bus_req.wdata;
      end
      else if (bus_req.addr == pin_mux_pkg::OFS_GPIO_OUT)
      begin
        gpio_out_reg <= bus_req.wdata[15:0];
      end
      else if (bus_req.addr == pin_mux_pkg::OFS_TX_SYNC)
      begin
        tx_sync_reg <= bus_req.wdata[7:0];
      end
      else if (bus_req.addr == pin_mux_pkg::OFS_TIMER_HIGH)
      begin
        timer_high_reg <= bus_req.wdata[7:0];
      end
      else if (bus_req.addr == pin_mux_pkg::OFS_CLK_SRC)
      begin
        clk_src_reg <= bus_req.wdata[7:0];
      end
      else
      begin
        // Line control, or an unmapped write which is dropped
        for (int c = 0; c < pin_mux_pkg::NUM_UART; c++)
        begin
          if (bus_req.addr == line_ofs(c))
          begin
            line_ctrl_reg[c] <= bus_req.wdata[7:0];
          end
        end
      end
    end
  end

  // ************************************************************
  // Pin events
  // ************************************************************
  // Any edge on an event-mode pin counts as activity
  always_comb
  begin
    event_set = '0;
    for (int i = 0; i < pin_mux_pkg::NUM_GPIO; i++)
    begin
      if (mode_of(gpio_mode_reg, i) == pin_mux_pkg::MODE_EVENT)
      begin
        event_set[i] = gpio_sync[i] ^ gpio_prev_reg[i];
      end
    end
  end

  // Write one to clear
  assign event_clr = (bus_req.wr && bus_req.addr == pin_mux_pkg::OFS_EVENT)
    ? bus_req.wdata[15:0] : 16'h0000;

  // Previous synced level, so edges compare stable samples
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      gpio_prev_reg <= pin_mux_pkg::RST_PIN_SYNC[15:0];
    end
    else
    begin
      gpio_prev_reg <= gpio_sync;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      event_reg <= '0;
    end
    else
    begin
      event_reg <= (event_reg & ~event_clr) | event_set;
    end
  end

  // Interrupt line follows pending flags one cycle later
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_n <= 1'b1;
    end
    else
    begin
      irq_n <= ~(|event_reg);
    end
  end

  // ************************************************************
  // General pin drive
  // ************************************************************
  // Overrides beat the configured function, purely combinational
  // so clearing one restores the pin at the very next edge
  always_comb
  begin
    drive_next = '0;
    for (int i = 0; i < pin_mux_pkg::NUM_GPIO; i++)
    begin
      case (mode_of(gpio_mode_reg, i))
        pin_mux_pkg::MODE_PUSH_PULL:
        begin
          drive_next.level[i] = gpio_out_reg[i];
          drive_next.enable[i] = 1'b1;
        end
        pin_mux_pkg::MODE_OPEN_DRAIN:
        begin
          // Only pulls low; a high is left to the pull resistor
          drive_next.level[i] = 1'b0;
          drive_next.enable[i] = ~gpio_out_reg[i];
        end
        default:
        begin
          // Input and event pins stay undriven
          drive_next.level[i] = 1'b0;
          drive_next.enable[i] = 1'b0;
        end
      endcase
      if (tx_sync_reg[pin_mux_pkg::OVR_BIT] && pin_mux_pkg::REFCLK_PINS[i])
      begin
        drive_next.level[i] = ref_clock_level;
        drive_next.enable[i] = 1'b1;
      end
      if (timer_high_reg[pin_mux_pkg::OVR_BIT] && pin_mux_pkg::TIMER_PINS[i])
      begin
        drive_next.level[i] = timer_level;
        drive_next.enable[i] = 1'b1;
      end
    end
  end

  // ************************************************************
  // UART pins
  // ************************************************************
  // Request-to-send: software level or a routed clock
  always_comb
  begin
    for (int c = 0; c < pin_mux_pkg::NUM_UART; c++)
    begin
      if (clk_src_reg[pin_mux_pkg::OVR_BIT])
      begin
        rts_next[c] = clk_src_reg[pin_mux_pkg::CLK_SRC_DIV_BIT]
          ? frac_div_level : uart_sys_clk_level;
      end
      else
      begin
        rts_next[c] = ~line_ctrl_reg[c][pin_mux_pkg::LINE_CTRL_RTS_BIT];
      end
    end
  end

  // All pin-side outputs registered; reset parks them idle
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      gpio_drive <= '0;
      rts_n_pin <= 4'hf;
      tx_pin <= 4'hf;
      uart_rxd <= 4'hf;
      cts_active <= 4'h0;
    end
    else
    begin
      gpio_drive <= drive_next;
      rts_n_pin <= rts_next;
      tx_pin <= uart_txd;
      uart_rxd <= rx_sync;
      cts_active <= ~cts_n_sync;
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  always_comb
  begin
    rd_data_next = pin_mux_pkg::RST_RD_DATA;
    if (!bus_req.rd)
    begin
      rd_data_next = pin_mux_pkg::RST_RD_DATA;
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_GPIO_MODE)
    begin
      rd_data_next = gpio_mode_reg;
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_GPIO_OUT)
    begin
      rd_data_next = {16'h0000, gpio_out_reg};
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_GPIO_IN)
    begin
      rd_data_next = {16'h0000, gpio_sync};
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_EVENT)
    begin
      rd_data_next = {16'h0000, event_reg};
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_TX_SYNC)
    begin
      rd_data_next = {24'h00_0000, tx_sync_reg};
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_TIMER_HIGH)
    begin
      rd_data_next = {24'h00_0000, timer_high_reg};
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_CLK_SRC)
    begin
      rd_data_next = {24'h00_0000, clk_src_reg};
    end
    else if (bus_req.addr == pin_mux_pkg::OFS_FLOW_STAT)
    begin
      rd_data_next = {24'h00_0000, rx_sync, cts_n_sync};
    end
    else
    begin
      // Line control, unmapped reads return zero
      for (int c = 0; c < pin_mux_pkg::NUM_UART; c++)
      begin
        if (bus_req.addr == line_ofs(c))
        begin
          rd_data_next = {24'h00_0000, line_ctrl_reg[c]};
        end
      end
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rd_data <= pin_mux_pkg::RST_RD_DATA;
    end
    else
    begin
      rd_data <= rd_data_next;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence ovr_released_s;
    $fell(tx_sync_reg[7]) && gpio_mode_reg[1:0] == 2'h0;
  endsequence

  sequence cts_low_held_s;
    !cts_n_pin[0] [*4];
  endsequence

  chk_gpio_input_quiet:
    assert property (gpio_mode_reg[5:4] == 2'h0 |=> !gpio_drive.enable[2])
    else $error("input pin driven");
  chk_open_drain_low:
    assert property (gpio_mode_reg[7:6] == 2'h2 && !gpio_out_reg[3]
      |=> gpio_drive.enable[3] && !gpio_drive.level[3])
    else $error("open-drain pin not pulling low");
  chk_event_flag_set:
    assert property (gpio_mode_reg[13:12] == 2'h3
      && $changed(gpio_sync[6]) |=> event_reg[6])
    else $error("event edge missed");
  chk_refclk_on_pin:
    assert property (tx_sync_reg[7] |=> gpio_drive.enable[8]
      && gpio_drive.level[8] == $past(ref_clock_level))
    else $error("reference clock not on pin");
  chk_timer_on_pin:
    assert property (timer_high_reg[7] |=> gpio_drive.enable[5]
      && gpio_drive.level[5] == $past(timer_level))
    else $error("timer not on pin");
  chk_rts_level:
    assert property (!clk_src_reg[7]
      |=> rts_n_pin[1] == !$past(line_ctrl_reg[1][7]))
    else $error("request level wrong");
  chk_rts_clock:
    assert property (clk_src_reg[7] && !clk_src_reg[0]
      |=> rts_n_pin[2] == $past(uart_sys_clk_level))
    else $error("clock not on request pin");
  chk_cts_status:
    assert property (cts_low_held_s |-> cts_active[0])
    else $error("clear-to-send not seen");
  chk_tx_own_pin:
    assert property (##1 tx_pin == $past(uart_txd))
    else $error("transmit pin mismatch");
  chk_irq_pending:
    assert property (event_reg != 16'h0000 |=> !irq_n)
    else $error("interrupt not asserted");
  chk_reset_quiet:
    assert property ($past(sys_rst) |-> gpio_drive.enable == 16'h0000
      && rts_n_pin == 4'hf)
    else $error("pins active after reset");
  chk_override_release:
    assert property (ovr_released_s |=> !gpio_drive.enable[0])
    else $error("pin not returned after override");

endmodule

`default_nettype wire

// File: rtl/sync_bits.sv
// Two-flop synchroniser for a vector of pin levels
`default_nettype none

module sync_bits
#(
  parameter int WIDTH = 24,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Levels in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second
  logic [WIDTH-1:0] meta_reg;

  // ************************************************************
  // Two stages
  // ************************************************************
  // Reset to the idle level so no false edge appears after release
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// File: verif/pin_side_model.sv
// Far-side model: pulled-down GPIO wires, RX and CTS transceivers
`default_nettype none

module pin_side_model
(
  // Device drive of the general pins
  input wire pin_mux_pkg::gpio_drive_t gpio_drive,
  // Far-side requests from the bench
  input wire logic [15:0] ext_en,
  input wire logic [15:0] ext_lvl,
  input wire logic [3:0] rx_lvl,
  input wire logic [3:0] cts_lvl,
  // Levels seen at the device pins
  output logic [15:0] gpio_in_pin,
  output logic [3:0] rx_pin,
  output logic [3:0] cts_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Wire resolution
  // ************************************************************
  // Device wins, then far side; a released wire sinks to the pulldown
  always_comb
  begin
    for (int i = 0; i < 16; i++)
      gpio_in_pin[i] = gpio_drive.enable[i] ? gpio_drive.level[i]
                     : ext_en[i] & ext_lvl[i];
  end

  // One receive line per channel, never shared
  assign rx_pin = rx_lvl;
  // Clear-to-send level straight from the far transceiver
  assign cts_n_pin = cts_lvl;
endmodule

`default_nettype wire

// File: verif/quad_uart_pin_function_mux_tb.sv
// Random self-checking bench for the quad UART pin function mux
`default_nettype none

module quad_uart_pin_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals
  // ************************************************************
  // Clock, reset and register bus
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  pin_mux_pkg::bus_req_t bus_req = '0;
  logic [31:0] rd_data;
  // Internal sources routed to pins
  logic ref_clock_level = 1'b0;
  logic timer_level = 1'b0;
  logic uart_sys_clk_level = 1'b0;
  logic frac_div_level = 1'b0;
  logic [3:0] uart_txd = 4'hf;
  // Pin side
  logic [15:0] gpio_in_pin;
  pin_mux_pkg::gpio_drive_t gpio_drive;
  logic [3:0] tx_pin, rx_pin, rts_n_pin, cts_n_pin;
  logic [3:0] uart_rxd, cts_active;
  logic irq_n;
  // Far-side requests, idle lines released
  logic [15:0] ext_en = 16'h0000;
  logic [15:0] ext_lvl = 16'h0000;
  logic [3:0] rx_lvl = 4'hf;
  logic [3:0] cts_lvl = 4'hf;
  // Scoreboard and seed
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  integer seed = 32'h01ed;

  // Free-running clock, 10 ns period
  always #5 ref_clk = ~ref_clk;

  quad_uart_pin_function_mux quad_uart_pin_function_mux_i
  (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .rd_data(rd_data), .ref_clock_level(ref_clock_level),
    .timer_level(timer_level), .uart_sys_clk_level(uart_sys_clk_level),
    .frac_div_level(frac_div_level), .uart_txd(uart_txd),
    .gpio_in_pin(gpio_in_pin), .gpio_drive(gpio_drive),
    .tx_pin(tx_pin), .rx_pin(rx_pin), .rts_n_pin(rts_n_pin),
    .cts_n_pin(cts_n_pin), .uart_rxd(uart_rxd),
    .cts_active(cts_active), .irq_n(irq_n)
  );

  pin_side_model pin_side_model_i
  (
    .gpio_drive(gpio_drive), .ext_en(ext_en), .ext_lvl(ext_lvl),
    .rx_lvl(rx_lvl), .cts_lvl(cts_lvl), .gpio_in_pin(gpio_in_pin),
    .rx_pin(rx_pin), .cts_n_pin(cts_n_pin)
  );

  // ************************************************************
  // Helpers
  // ************************************************************
  // Counts, verdict and end of run
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Plain value compare
  task automatic cmp_val(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Pin drive compare; level only matters where driven
  task automatic cmp_drive(logic [31:0] e);
    cmp_val("gpio_drive", e, {gpio_drive.level & gpio_drive.enable,
                              gpio_drive.enable});
  endtask

  // One-cycle write strobe
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask

  // Read strobe, data taken in the following cycle only
  task automatic rd_chk(logic [7:0] a, logic [31:0] e, string nm);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    cmp_val(nm, e, rd_data);
  endtask

  // Let n edges pass, then sample where outputs are settled
  task automatic settle(int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Expected {driven level, enable}: overrides beat the mode
  function automatic logic [31:0] exp_drive(logic [31:0] m,
    logic [15:0] o, logic ts, logic tm, logic rl, logic tl);
    logic [15:0] en;
    logic [15:0] lv;
    for (int i = 0; i < 16; i++)
    begin
      en[i] = m[2*i+:2] == pin_mux_pkg::MODE_PUSH_PULL ||
              (m[2*i+:2] == pin_mux_pkg::MODE_OPEN_DRAIN && !o[i]);
      lv[i] = m[2*i+:2] == pin_mux_pkg::MODE_PUSH_PULL && o[i];
      if (ts && pin_mux_pkg::REFCLK_PINS[i])
        {en[i], lv[i]} = {1'b1, rl};
      if (tm && pin_mux_pkg::TIMER_PINS[i])
        {en[i], lv[i]} = {1'b1, tl};
    end
    return {lv & en, en};
  endfunction

  // Hang guard: far above the expected run length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    logic [31:0] m;
    logic [31:0] e;
    logic [15:0] o;
    logic ts, tm;
    logic [3:0] v, r;
    // Reset held for 8 edges; pins parked while it lasts
    settle(7);
    cmp_drive(32'h0);
    cmp_val("rts_n_pin", 32'hf, {28'h0, rts_n_pin});
    cmp_val("irq_n", 32'h1, {31'h0, irq_n});
    cmp_val("rd_data", 32'h0, rd_data);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Random modes, levels and overrides set and cleared
    for (int k = 0; k < 16; k++)
    begin
      m = $random(seed);
      o = 16'($random(seed));
      {ts, tm} = 2'($random(seed));
      wr(pin_mux_pkg::OFS_GPIO_MODE, m);
      wr(pin_mux_pkg::OFS_GPIO_OUT, {16'h0, o});
      wr(pin_mux_pkg::OFS_TX_SYNC, {24'h0, ts, 7'h0});
      wr(pin_mux_pkg::OFS_TIMER_HIGH, {24'h0, tm, 7'h0});
      @(posedge ref_clk);
      ref_clock_level <= ~ref_clock_level;
      timer_level <= 1'($random(seed));
      settle(1);
      e = exp_drive(m, o, ts, tm, ref_clock_level, timer_level);
      cmp_drive(e);
      settle(3);
      rd_chk(pin_mux_pkg::OFS_GPIO_IN, {16'h0, e[31:16]}, "gpio_in");
      rd_chk(pin_mux_pkg::OFS_GPIO_MODE, m, "mode");
      rd_chk(pin_mux_pkg::OFS_TX_SYNC, {24'h0, ts, 7'h0}, "sync");
    end
    // Unmapped place: write ignored, read gives zero
    wr(8'hf0, $random(seed));
    rd_chk(8'hf0, 32'h0, "unmapped");
    // Pin 6 as event source, pin 7 plain input
    wr(pin_mux_pkg::OFS_GPIO_MODE, 32'h0000_3000);
    wr(pin_mux_pkg::OFS_TIMER_HIGH, 32'h0);
    // Override on then off: pins 0,4,8 back to inputs next cycle
    wr(pin_mux_pkg::OFS_TX_SYNC, 32'h80);
    wr(pin_mux_pkg::OFS_TX_SYNC, 32'h0);
    settle(1);
    cmp_drive(32'h0);
    settle(3);
    wr(pin_mux_pkg::OFS_EVENT, 32'h0000_ffff);
    settle(2);
    cmp_val("irq_n", 32'h1, {31'h0, irq_n});
    @(posedge ref_clk);
    ext_en <= 16'h00c0;
    ext_lvl <= 16'h00c0;
    settle(6);
    cmp_val("irq_n", 32'h0, {31'h0, irq_n});
    rd_chk(pin_mux_pkg::OFS_EVENT, 32'h40, "events");
    wr(pin_mux_pkg::OFS_EVENT, 32'h40);
    settle(2);
    cmp_val("irq_n", 32'h1, {31'h0, irq_n});
    // Serial lines, flow status and request-to-send
    for (int k = 0; k < 6; k++)
    begin
      {v, r} = 8'($random(seed));
      @(posedge ref_clk);
      rx_lvl <= v;
      cts_lvl <= r;
      uart_txd <= ~v;
      settle(1);
      cmp_val("tx_pin", {28'h0, ~v}, {28'h0, tx_pin});
      settle(3);
      cmp_val("uart_rxd", {28'h0, v}, {28'h0, uart_rxd});
      cmp_val("cts_active", {28'h0, ~r}, {28'h0, cts_active});
      rd_chk(pin_mux_pkg::OFS_FLOW_STAT, {24'h0, v, r}, "flow");
      for (int c = 0; c < 4; c++)
        wr(pin_mux_pkg::OFS_LINE_CTRL0 + 8'(4 * c), {24'h0, r[c], 7'h0});
      settle(1);
      cmp_val("rts_n_pin", {28'h0, ~r}, {28'h0, rts_n_pin});
      wr(pin_mux_pkg::OFS_CLK_SRC, {24'h0, 1'b1, 6'h0, v[0]});
      repeat (3)
      begin
        @(posedge ref_clk);
        uart_sys_clk_level <= ~uart_sys_clk_level;
        frac_div_level <= 1'($random(seed));
        settle(1);
        e = {28'h0, {4{v[0] ? frac_div_level : uart_sys_clk_level}}};
        cmp_val("rts_clk", e, {28'h0, rts_n_pin});
      end
      wr(pin_mux_pkg::OFS_CLK_SRC, 32'h0);
      settle(1);
      cmp_val("rts_n_pin", {28'h0, ~r}, {28'h0, rts_n_pin});
    end
    // Reset in mid-run parks driven pins again
    wr(pin_mux_pkg::OFS_GPIO_MODE, 32'h5555_5555);
    wr(pin_mux_pkg::OFS_GPIO_OUT, 32'h0000_ffff);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    settle(2);
    cmp_drive(32'h0);
    cmp_val("rts_n_pin", 32'hf, {28'h0, rts_n_pin});
    cmp_val("tx_pin", 32'hf, {28'h0, tx_pin});
    stop_test();
  end
endmodule

`default_nettype wire
